// ---- verilog/sbc_top.sv ----
// Serial bus condition detector and acknowledge/busy driver with APB registers
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - Release flag sets when data rises with clock high; reads zero otherwise.
// - Command flag sets when data falls with clock high; reads zero otherwise.
// - Writing one to the trigger bit drives acknowledge; zero does nothing.
// - Auto acknowledge enable set: acknowledge driven after each received byte.
// - Acknowledge flag reads one once an acknowledge from the bus is seen.
// - Busy enable bit; when zero no automatic busy is driven.
// - Release and command conditions have separate status flags.
module sbc_top
   import sbc_pkg::*;
(
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic SCK,
   input wire logic SB_I,
   output logic SB_O,
   output logic SB_OE,
   output logic IRQ
);
   logic [1:0] pin_sync;
   logic sck_s;
   logic sb_s;
   logic sck_d_r;
   logic sb_d_r;
   logic sck_rise;
   logic sck_fall;
   logic sb_rise;
   logic sb_fall;
   sbc_evt_s evt;
   sbc_ctrl_s ctrl_r;
   logic release_detected_flag_r;
   logic command_detected_flag_r;
   logic ack_detected_flag_r;
   logic active_r;
   logic [3:0] bit_cnt_r;
   logic [3:0] bit_cnt_nxt;
   logic ack_auto_r;
   logic ack_trig_r;
   logic busy_r;
   logic [SBC_EV_NUM-1:0] ev_mask_r;
   logic [SBC_EV_NUM-1:0] ev_stat_r;
   logic [SBC_EV_NUM-1:0] ev_clr_r;
   logic [SBC_EV_NUM-1:0] ev_clr;
   logic setup;
   logic access;
   logic wr_en;
   logic rd_ist;
   logic addr_ok;
   logic ack_trigger_bit;
   logic ready_bit;
   logic sync_restart;
   logic byte_end_fall;

   // Both pins pass two flops before any detector reads them
   sbc_sync #(
      .W(2)
   ) u_sync (
      .clk(MCLK),
      .srst(SRST),
      .async_in({SCK, SB_I}),
      .sync_out(pin_sync)
   );

   assign sck_s = pin_sync[1];
   assign sb_s = pin_sync[0];

   // Delayed copies for edge finding
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         sck_d_r <= 1'b1;
         sb_d_r <= 1'b1;
      end
      else
      begin
         sck_d_r <= sck_s;
         sb_d_r <= sb_s;
      end
   end

   assign sck_rise = sck_s & ~sck_d_r;
   assign sck_fall = ~sck_s & sck_d_r;
   assign sb_rise = sb_s & ~sb_d_r;
   assign sb_fall = ~sb_s & sb_d_r;

   // Conditions need clock high before and after the data edge, so a
   // data change racing a clock edge is not taken for a condition
   always_comb
   begin
      evt.release_seen = sb_rise & sck_s & sck_d_r;
      evt.command_seen = sb_fall & sck_s & sck_d_r;
      // Acknowledge is the data level seen at the ninth clock rise
      evt.ack_seen = active_r & sck_rise & (bit_cnt_nxt == SBC_CNT_ACK)
                     & ~sb_s;
      evt.byte_done = active_r & sck_rise & (bit_cnt_nxt == SBC_CNT_ACK);
   end
   assign sync_restart = evt.release_seen | evt.command_seen;
   assign byte_end_fall = active_r & sck_fall & (bit_cnt_r == SBC_CNT_ACK);

   // Clock count within a frame: one to eight data, nine acknowledge
   always_comb
   begin
      if (bit_cnt_r == SBC_CNT_ACK)
         bit_cnt_nxt = SBC_CNT_FIRST;
      else
         bit_cnt_nxt = bit_cnt_r + SBC_CNT_FIRST;
   end

   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         active_r <= 1'b0;
         bit_cnt_r <= SBC_CNT_IDLE;
      end
      else if (evt.command_seen)
      begin
         active_r <= 1'b1;
         bit_cnt_r <= SBC_CNT_IDLE;
      end
      else if (evt.release_seen)
      begin
         active_r <= 1'b0;
         bit_cnt_r <= SBC_CNT_IDLE;
      end
      else if (active_r && sck_rise)
         bit_cnt_r <= bit_cnt_nxt;
   end

   // Each condition flag is cleared by the other condition, keeping the
   // two distinguishable; the newer condition is the one that reads one
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         release_detected_flag_r <= 1'b0;
         command_detected_flag_r <= 1'b0;
      end
      else if (evt.release_seen)
      begin
         release_detected_flag_r <= 1'b1;
         command_detected_flag_r <= 1'b0;
      end
      else if (evt.command_seen)
      begin
         command_detected_flag_r <= 1'b1;
         release_detected_flag_r <= 1'b0;
      end
   end

   // Acknowledge flag lives until a command or release condition is seen or the next byte begins
   always_ff @(posedge MCLK)
   begin
      if (SRST)
         ack_detected_flag_r <= 1'b0;
      else if (evt.ack_seen)
         ack_detected_flag_r <= 1'b1;
      else if (sync_restart || (active_r && sck_rise))
         ack_detected_flag_r <= 1'b0;
   end

   // Automatic acknowledge from the fall after clock eight to the fall
   // after clock nine, so the pin is stable through the ninth high phase
   always_ff @(posedge MCLK)
   begin
      if (SRST)
         ack_auto_r <= 1'b0;
      else if (sync_restart || byte_end_fall)
         ack_auto_r <= 1'b0;
      else if (active_r && sck_fall && bit_cnt_r == SBC_CNT_LAST_DATA
               && ctrl_r.auto_ack_enable)
         ack_auto_r <= 1'b1;
   end

   // Software acknowledge held until the acknowledge clock has passed
   always_ff @(posedge MCLK)
   begin
      if (SRST)
         ack_trig_r <= 1'b0;
      else if (wr_en && PADDR == SBC_CTRL_OFS && ack_trigger_bit)
         ack_trig_r <= 1'b1;
      else if (sync_restart || byte_end_fall)
         ack_trig_r <= 1'b0;
   end

   // Busy pulls data low after the acknowledge until software is ready
   always_ff @(posedge MCLK)
   begin
      if (SRST)
         busy_r <= 1'b0;
      else if (byte_end_fall && ctrl_r.auto_busy_enable)
         busy_r <= 1'b1;
      else if (sync_restart || !ctrl_r.auto_busy_enable
               || (wr_en && PADDR == SBC_CTRL_OFS && ready_bit))
         busy_r <= 1'b0;
   end

   // Open drain: only ever pulls low
   assign SB_O = 1'b0;
   assign SB_OE = ack_auto_r | ack_trig_r | busy_r;

   // APB decode; no wait states
   assign setup = PSEL & ~PENABLE;
   assign access = PSEL & PENABLE;
   assign addr_ok = (PADDR == SBC_CTRL_OFS) || (PADDR == SBC_STAT_OFS)
                    || (PADDR == SBC_IST_OFS) || (PADDR == SBC_IMSK_OFS);
   assign wr_en = access & PWRITE & addr_ok;
   assign rd_ist = access & ~PWRITE & (PADDR == SBC_IST_OFS);
   assign PREADY = 1'b1;
   assign PSLVERR = access & ~addr_ok;
   assign ack_trigger_bit = PWDATA[SBC_CTRL_ACK_TRIGGER_BIT_BIT];
   assign ready_bit = PWDATA[SBC_CTRL_RDY_BIT];

   // Control and mask registers
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         ctrl_r <= '0;
         ev_mask_r <= SBC_ZERO_EV;
      end
      else if (wr_en)
      begin
         if (PADDR == SBC_CTRL_OFS)
         begin
            ctrl_r.auto_ack_enable <= PWDATA[SBC_CTRL_AUTO_ACK_ENABLE_BIT];
            ctrl_r.auto_busy_enable <= PWDATA[SBC_CTRL_AUTO_BUSY_ENABLE_BIT];
         end
         if (PADDR == SBC_IMSK_OFS)
            ev_mask_r <= PWDATA[SBC_EV_NUM-1:0];
      end
   end

   // Read data captured in setup so the access phase sees stable bits
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         PRDATA <= SBC_ZERO32;
         ev_clr_r <= SBC_ZERO_EV;
      end
      else if (setup)
      begin
         PRDATA <= SBC_ZERO32;
         ev_clr_r <= SBC_ZERO_EV;
         if (!PWRITE)
         begin
            case (PADDR)
               SBC_CTRL_OFS:
               begin
                  PRDATA[SBC_CTRL_AUTO_ACK_ENABLE_BIT] <= ctrl_r.auto_ack_enable;
                  PRDATA[SBC_CTRL_AUTO_BUSY_ENABLE_BIT] <= ctrl_r.auto_busy_enable;
               end
               SBC_STAT_OFS:
               begin
                  PRDATA[SBC_STAT_REL_BIT] <= release_detected_flag_r;
                  PRDATA[SBC_STAT_CMD_BIT] <= command_detected_flag_r;
                  PRDATA[SBC_STAT_ACK_DETECTED_FLAG_BIT] <= ack_detected_flag_r;
                  PRDATA[SBC_STAT_BUSY_BIT] <= busy_r;
                  PRDATA[SBC_STAT_ACKO_BIT] <= ack_auto_r | ack_trig_r;
                  PRDATA[SBC_STAT_CNT_LSB +: 4] <= bit_cnt_r;
               end
               SBC_IST_OFS:
               begin
                  PRDATA[SBC_EV_NUM-1:0] <= ev_stat_r;
                  ev_clr_r <= ev_stat_r;
               end
               SBC_IMSK_OFS:
                  PRDATA[SBC_EV_NUM-1:0] <= ev_mask_r;
               default:
                  PRDATA <= SBC_ZERO32;
            endcase
         end
      end
   end

   // Only bits that software actually saw are cleared by the read
   assign ev_clr = rd_ist ? ev_clr_r : SBC_ZERO_EV;

   sbc_irq #(
      .N(SBC_EV_NUM)
   ) u_irq (
      .clk(MCLK),
      .srst(SRST),
      .ev_set(evt),
      .ev_clr(ev_clr),
      .ev_mask(ev_mask_r),
      .ev_stat_r(ev_stat_r),
      .irq(IRQ)
   );
endmodule

// ---- verilog/sbc_pkg.sv ----
// Package of constants and types for the serial bus condition control block
package sbc_pkg;
   // Register byte offsets
   localparam logic [11:0] SBC_CTRL_OFS = 12'h000;
   localparam logic [11:0] SBC_STAT_OFS = 12'h004;
   localparam logic [11:0] SBC_IST_OFS = 12'h008;
   localparam logic [11:0] SBC_IMSK_OFS = 12'h00c;
   // Control register fields
   localparam int SBC_CTRL_ACK_TRIGGER_BIT_BIT = 0;
   localparam int SBC_CTRL_AUTO_ACK_ENABLE_BIT = 1;
   localparam int SBC_CTRL_AUTO_BUSY_ENABLE_BIT = 2;
   localparam int SBC_CTRL_RDY_BIT = 3;
   // Status register fields
   localparam int SBC_STAT_REL_BIT = 0;
   localparam int SBC_STAT_CMD_BIT = 1;
   localparam int SBC_STAT_ACK_DETECTED_FLAG_BIT = 2;
   localparam int SBC_STAT_BUSY_BIT = 3;
   localparam int SBC_STAT_ACKO_BIT = 4;
   localparam int SBC_STAT_CNT_LSB = 8;
   // Interrupt events
   localparam int SBC_EV_NUM = 4;
   localparam int SBC_EV_REL = 0;
   localparam int SBC_EV_CMD = 1;
   localparam int SBC_EV_ACK_DETECTED_FLAG = 2;
   localparam int SBC_EV_BYTE = 3;
   // Serial framing: eight data clocks, ninth clock is acknowledge
   localparam logic [3:0] SBC_CNT_IDLE = 4'h0;
   localparam logic [3:0] SBC_CNT_FIRST = 4'h1;
   localparam logic [3:0] SBC_CNT_LAST_DATA = 4'h8;
   localparam logic [3:0] SBC_CNT_ACK = 4'h9;
   localparam logic [31:0] SBC_ZERO32 = 32'h0000_0000;
   localparam logic [3:0] SBC_ZERO_EV = 4'h0;

   // Software written control bits
   typedef struct packed {
      logic auto_busy_enable;
      logic auto_ack_enable;
   } sbc_ctrl_s;

   // Bus condition events of one clock
   typedef struct packed {
      logic byte_done;
      logic ack_seen;
      logic command_seen;
      logic release_seen;
   } sbc_evt_s;
endpackage

// ---- verilog/sbc_sync.sv ----
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module sbc_sync
   import sbc_pkg::*;
#(
   parameter int W = 2
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_r;

   initial
   begin
      if (W < 1)
         $error("sbc_sync: width must be at least one");
   end

   // First stage feeds only the second stage
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         meta_r <= '1;
         sync_out <= '1;
      end
      else
      begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule

// ---- verilog/sbc_irq.sv ----
// Sticky interrupt status with read-clear and mask gating
`timescale 1ns/1ps
module sbc_irq
   import sbc_pkg::*;
#(
   parameter int N = SBC_EV_NUM
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [N-1:0] ev_set,
   input wire logic [N-1:0] ev_clr,
   input wire logic [N-1:0] ev_mask,
   output logic [N-1:0] ev_stat_r,
   output logic irq
);
   initial
   begin
      if (N < 1)
         $error("sbc_irq: need at least one event");
   end

   // Set beats clear so an event in the clearing cycle survives
   always_ff @(posedge clk)
   begin
      if (srst)
         ev_stat_r <= '0;
      else
         ev_stat_r <= (ev_stat_r & ~ev_clr) | ev_set;
   end

   // Level output while any unmasked bit stands
   assign irq = |(ev_stat_r & ev_mask);
endmodule

// ---- testbench/sbc_station.sv ----
// Other station on the two-wire serial bus: drives clock and data
`timescale 1ns/1ps
module sbc_station
(
   output logic sck,
   output logic sb,
   input wire logic sb_oe
);
   logic low = 1'b0;
   int hp = 32;
   // Open drain wire with pull-up: low while anyone pulls
   assign sb = !(low || sb_oe);
   initial sck = 1'b1;
   // Data falls while the clock stands high
   task cmd;
      #3 low = 1'b1;
      #hp;
   endtask
   // Data rises while the clock is high; clock then idles high
   task bus_release_condition;
      #3 low = 1'b1;
      #hp sck = 1'b1;
      #hp low = 1'b0;
      #hp;
   endtask
   // Data moves only 8 after the clock falls, early in the low phase, so no false condition is seen
   task byt(input logic [7:0] d, input logic sa, output logic ack);
      #3;
      for (int i = 8; i >= 0; i--)
      begin
         sck = 1'b0;
         #8 low = (i == 0) ? sa : !d[i-1];
         #(hp-8) sck = 1'b1;
         ack = sb;
         #hp;
      end
      sck = 1'b0;
      #8 low = 1'b0;
      #hp;
   endtask
endmodule

// ---- testbench/sbc_top_props.sv ----
// Port-level assertions for the serial bus condition block
`timescale 1ns/1ps
module sbc_props
   import sbc_pkg::*;
(
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic SCK,
   input wire logic SB_I,
   input wire logic SB_O,
   input wire logic SB_OE,
   input wire logic IRQ
);
   logic [2:0] ctl_r;
   logic [3:0] msk_r;
   logic wr;
   logic cw;
   logic tw;
   // Completed writes; trigger write is a control write with bit 0 set
   assign wr = PSEL && PENABLE && PWRITE && PREADY;
   assign cw = wr && PADDR == SBC_CTRL_OFS;
   assign tw = cw && PWDATA[0];
   // Shadow of control bits as software wrote them
   always_ff @(posedge MCLK)
      if (SRST)
         ctl_r <= 3'h0;
      else if (cw)
         ctl_r <= PWDATA[2:0];
   // Shadow of the interrupt mask
   always_ff @(posedge MCLK)
      if (SRST)
         msk_r <= 4'h0;
      else if (wr && PADDR == SBC_IMSK_OFS)
         msk_r <= PWDATA[3:0];
   default clocking @(posedge MCLK); endclocking
   default disable iff (SRST);
   property p_trig;
      tw |-> ##[1:2] SB_OE;
   endproperty
   a_trig: assert property (p_trig) else $error("trigger gave no drive");
   property p_zero;
      SCK [*6] ##0 (cw && PWDATA[2:0] == 3'h0 && !SB_OE) |=> !SB_OE [*2];
   endproperty
   a_zero: assert property (p_zero) else $error("drive without trigger");
   property p_sbo;
      SB_O == 1'b0;
   endproperty
   a_sbo: assert property (p_sbo) else $error("pin driven high");
   // Auto drive starts from the enable bits as they stood before the rise
   property p_rise;
      $rose(SB_OE) |-> $past(tw) || $past(ctl_r[1]) || $past(ctl_r[2]);
   endproperty
   a_rise: assert property (p_rise) else $error("auto drive while disabled");
   property p_bsy;
      $rose(SB_OE) && !ctl_r[2] |-> ##[1:200] !SB_OE;
   endproperty
   a_bsy: assert property (p_bsy) else $error("drive held, busy off");
   property p_excl;
      PSEL && PENABLE && !PWRITE && PADDR == SBC_STAT_OFS |-> !(PRDATA[0] && PRDATA[1]);
   endproperty
   a_excl: assert property (p_excl) else $error("both conditions flagged");
   property p_irq;
      msk_r == 4'h0 |-> !IRQ;
   endproperty
   a_irq: assert property (p_irq) else $error("masked interrupt seen");
endmodule
bind sbc_top sbc_props u_props(.MCLK(MCLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .SCK(SCK), .SB_I(SB_I), .SB_O(SB_O), .SB_OE(SB_OE), .IRQ(IRQ));

// ---- testbench/sbc_top_test.sv ----
// Self-checking bench for the serial bus condition block
`timescale 1ns/1ps
module sbc_top_test
   import sbc_pkg::*;
;
   logic mclk = 1'b0;
   logic srst, psel, penable, pwrite, pready, pslverr, irq, sb_o, sb_oe, sck, sb, a, perr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #4 mclk = ~mclk;
   sbc_top DUT(.MCLK(mclk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .SCK(sck), .SB_I(sb), .SB_O(sb_o), .SB_OE(sb_oe), .IRQ(irq));
   sbc_station st(.sck(sck), .sb(sb), .sb_oe(sb_oe));
   task end_of_test;
      if (fail_count == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   // One transfer started on an edge; request held until pready is sampled high
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1)
         @(posedge mclk);
      r = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task rd(input logic [11:0] ad, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, ad, 32'h0);
      chk(r & m, e);
   endtask
   // Hang guard, well above the roughly five hundred cycles needed
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         fail_count++;
         end_of_test();
      end
   end
   initial
   begin
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      repeat (16) @(posedge mclk);
      srst <= 1'b0;
      rd(SBC_CTRL_OFS, 32'hffffffff, 32'h0);
      rd(SBC_STAT_OFS, 32'hffffffff, 32'h0);
      rd(SBC_IST_OFS, 32'hffffffff, 32'h0);
      rd(12'h010, 32'hffffffff, 32'h0);
      chk(perr, 32'h1);
      apb(1'b1, SBC_IMSK_OFS, 32'hf);
      st.cmd();
      rd(SBC_STAT_OFS, 32'h3, 32'h2);
      chk(irq, 32'h1);
      rd(SBC_IST_OFS, 32'hf, 32'h2);
      @(posedge mclk);
      chk(irq, 32'h0);
      st.byt(8'ha5, 1'b1, a);
      rd(SBC_STAT_OFS, 32'hffffffff, 32'h906);
      rd(SBC_IST_OFS, 32'hf, 32'hc);
      st.byt(8'h3c, 1'b0, a);
      chk(a, 32'h1);
      rd(SBC_STAT_OFS, 32'h4, 32'h0);
      apb(1'b1, SBC_CTRL_OFS, 32'h2);
      st.byt(8'h81, 1'b0, a);
      chk(a, 32'h0);
      repeat (4) @(posedge mclk);
      chk(sb_oe, 32'h0);
      apb(1'b1, SBC_CTRL_OFS, 32'h6);
      st.byt(8'h7e, 1'b0, a);
      chk(a, 32'h0);
      rd(SBC_STAT_OFS, 32'h18, 32'h8);
      chk(sb_oe, 32'h1);
      apb(1'b1, SBC_CTRL_OFS, 32'he);
      chk(sb_oe, 32'h0);
      st.bus_release_condition();
      rd(SBC_STAT_OFS, 32'h3, 32'h1);
      apb(1'b1, SBC_STAT_OFS, 32'h2);
      rd(SBC_STAT_OFS, 32'h3, 32'h1);
      rd(SBC_IST_OFS, 32'h3, 32'h1);
      apb(1'b1, SBC_CTRL_OFS, 32'h0);
      chk(sb_oe, 32'h0);
      st.cmd();
      rd(SBC_STAT_OFS, 32'h3, 32'h2);
      apb(1'b1, SBC_CTRL_OFS, 32'h1);
      chk(sb_oe, 32'h1);
      rd(SBC_CTRL_OFS, 32'hf, 32'h0);
      rd(SBC_STAT_OFS, 32'h10, 32'h10);
      st.byt(8'h55, 1'b0, a);
      chk(a, 32'h0);
      repeat (4) @(posedge mclk);
      chk(sb_oe, 32'h0);
      end_of_test();
   end
endmodule
